// >>> logic/vdbg_consts.svh
// offsets, field positions, reset values and counts of the video debug block
`ifndef VDBG_CONSTS_SVH
`define VDBG_CONSTS_SVH
`define VDBG_OFS_CTRL       8'h00
`define VDBG_OFS_FRAME      8'h14
`define VDBG_OFS_LINE       8'h18
`define VDBG_OFS_PIXEL      8'h1C
`define VDBG_OFS_SIZE       8'h20
`define VDBG_BIT_PASS       4
`define VDBG_BIT_PATTERN    5
`define VDBG_BIT_SWRST      30
`define VDBG_RST_WIDTH      13'h0780
`define VDBG_RST_HEIGHT     13'h0438
`define VDBG_BAR_LINES      13'h0100
`define VDBG_BAR_MSB        8
`define VDBG_BAR_LSB        6
`define VDBG_G_MSB          7
`define VDBG_G_LSB          0
`define VDBG_B_MSB          15
`define VDBG_B_LSB          8
`define VDBG_R_MSB          23
`define VDBG_R_LSB          16
`define VDBG_RESP_OKAY      2'h0
`define VDBG_RESP_SLVERR    2'h2
`endif

// >>> logic/vdbg_pkg.sv
// types of the video debug block
`default_nettype none
package vdbg_pkg;
  typedef enum logic [2:0] {
    VDBG_MODE_NORMAL  = 3'h1,
    VDBG_MODE_PASS    = 3'h2,
    VDBG_MODE_PATTERN = 3'h4
  } vdbg_mode_type;

  typedef struct packed {
    logic [12:0] x;
    logic [12:0] y;
  } vdbg_pg_state_type;

  typedef struct packed {
    logic          pass;
    logic          pattern;
    logic          swrst;
    logic [12:0]   width;
    logic [12:0]   height;
    logic [31:0]   frames;
    logic [31:0]   lines;
    logic [31:0]   pixels;
    logic          awready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    vdbg_mode_type mode;
    logic          in_ready;
    logic          s_ready;
    logic          conv_ready;
    logic [23:0]   out_data;
    logic          out_last;
    logic          out_user;
    logic          out_valid;
    logic [23:0]   skid_data;
    logic          skid_last;
    logic          skid_user;
    logic          skid_valid;
  } vdbg_state_type;
endpackage
`default_nettype wire

// >>> logic/vdbg_pattern_gen.sv
// test pattern generator: colour bars then a grey ramp
`timescale 1ns/100ps
`default_nettype none
`include "vdbg_consts.svh"
module vdbg_pattern_gen (
  input  wire logic        clk_sys,  // stream clock
  input  wire logic        nrst,     // async reset, active low
  input  wire logic        clr,      // restart at frame origin
  input  wire logic        advance,  // one pixel taken
  input  wire logic [12:0] width,    // pixels per line
  input  wire logic [12:0] height,   // lines per frame
  output logic      [23:0] pix,      // pixel value
  output logic             sof,      // first pixel of frame
  output logic             eol       // last pixel of line
);
  vdbg_pkg::vdbg_pg_state_type st_reg;
  vdbg_pkg::vdbg_pg_state_type st_next;
  logic [2:0] bar;
  logic [7:0] ramp;
  logic       end_x;
  logic       end_y;

  assign end_x = ({1'b0, st_reg.x} + 14'h0001) >= {1'b0, width};
  assign end_y = ({1'b0, st_reg.y} + 14'h0001) >= {1'b0, height};
  assign bar   = st_reg.x[`VDBG_BAR_MSB:`VDBG_BAR_LSB];
  assign ramp  = st_reg.x[7:0] + st_reg.y[7:0];
  assign sof   = (st_reg.x == 13'h0000) && (st_reg.y == 13'h0000);
  assign eol   = end_x;

  always_comb begin
    // bar index bits map to red, green, blue: black,red,green,yellow,blue,magenta,cyan,white
    pix = {24{1'b0}};
    if (st_reg.y < `VDBG_BAR_LINES) begin
      pix[`VDBG_R_MSB:`VDBG_R_LSB] = {8{bar[0]}};
      pix[`VDBG_G_MSB:`VDBG_G_LSB] = {8{bar[1]}};
      pix[`VDBG_B_MSB:`VDBG_B_LSB] = {8{bar[2]}};
    end else begin
      pix = {ramp, ramp, ramp};
    end
  end

  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next = '0;
    end else if (advance) begin
      if (end_x) begin
        st_next.x = 13'h0000;
        st_next.y = end_y ? 13'h0000 : st_reg.y + 13'h0001;
      end else begin
        st_next.x = st_reg.x + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // vdbg_pattern_gen
`default_nettype wire

// >>> logic/vdbg_top.sv
// video debug block: green-only raw passthrough, pattern source, throughput monitors, register slave
`timescale 1ns/100ps
`default_nettype none
`include "vdbg_consts.svh"
module vdbg_top #(
  parameter bit DEBUG_INCLUDE = 1'b1,  // generation option for the debug logic
  parameter bit REGIF_PRESENT = 1'b1   // register interface present
) (
  input  wire logic        clk_sys,               // stream clock
  input  wire logic        nrst,                  // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,          // write address
  input  wire logic        s_axi_awvalid,         // write address valid
  output logic             s_axi_awready,         // write address ready
  input  wire logic [31:0] s_axi_wdata,           // write data
  input  wire logic [3:0]  s_axi_wstrb,           // write byte strobes
  input  wire logic        s_axi_wvalid,          // write data valid
  output logic             s_axi_wready,          // write data ready
  output logic [1:0]       s_axi_bresp,           // write response
  output logic             s_axi_bvalid,          // write response valid
  input  wire logic        s_axi_bready,          // write response ready
  input  wire logic [7:0]  s_axi_araddr,          // read address
  input  wire logic        s_axi_arvalid,         // read address valid
  output logic             s_axi_arready,         // read address ready
  output logic [31:0]      s_axi_rdata,           // read data
  output logic [1:0]       s_axi_rresp,           // read response
  output logic             s_axi_rvalid,          // read data valid
  input  wire logic        s_axi_rready,          // read data ready
  input  wire logic [23:0] s_axis_video_tdata,    // raw input sample
  input  wire logic        s_axis_video_tvalid,   // raw input valid
  input  wire logic        s_axis_video_tlast,    // raw input end of line
  input  wire logic        s_axis_video_tuser,    // raw input start of frame
  output logic             s_axis_video_tready,   // raw input ready
  input  wire logic [23:0] conv_tdata,            // converted sample
  input  wire logic        conv_tvalid,           // converted valid
  input  wire logic        conv_tlast,            // converted end of line
  input  wire logic        conv_tuser,            // converted start of frame
  output logic             conv_tready,           // converted ready
  output logic [23:0]      m_axis_video_tdata,    // output sample
  output logic             m_axis_video_tvalid,   // output valid
  output logic             m_axis_video_tlast,    // output end of line
  output logic             m_axis_video_tuser,    // output start of frame
  input  wire logic        m_axis_video_tready    // output ready
);
  localparam bit DBG_ON = DEBUG_INCLUDE && REGIF_PRESENT;

  vdbg_pkg::vdbg_state_type st_reg;
  vdbg_pkg::vdbg_state_type st_next;
  logic [7:0]  waddr;
  logic [7:0]  raddr;
  logic [23:0] pg_pix;
  logic        pg_sof;
  logic        pg_eol;
  logic        pg_adv;
  logic        pg_clr;
  logic [23:0] sel_data;
  logic        sel_last;
  logic        sel_user;
  logic        sel_valid;
  logic        acc;
  logic        pop;

  assign waddr  = {s_axi_awaddr[7:2], 2'b00};
  assign raddr  = {s_axi_araddr[7:2], 2'b00};
  assign pop    = st_reg.out_valid && m_axis_video_tready;
  assign acc    = sel_valid && st_reg.in_ready;
  assign pg_adv = acc && (st_reg.mode == vdbg_pkg::VDBG_MODE_PATTERN);
  // restarting outside pattern mode makes every enable begin a fresh frame
  assign pg_clr = st_reg.swrst || (st_reg.mode != vdbg_pkg::VDBG_MODE_PATTERN);

  vdbg_pattern_gen u_pg (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clr     (pg_clr),
    .advance (pg_adv),
    .width   (st_reg.width),
    .height  (st_reg.height),
    .pix     (pg_pix),
    .sof     (pg_sof),
    .eol     (pg_eol)
  );

  always_comb begin
    sel_data  = conv_tdata;
    sel_last  = conv_tlast;
    sel_user  = conv_tuser;
    sel_valid = conv_tvalid;
    case (st_reg.mode)
      vdbg_pkg::VDBG_MODE_PATTERN: begin
        sel_data  = pg_pix;
        sel_last  = pg_eol;
        sel_user  = pg_sof;
        sel_valid = 1'b1;
      end
      vdbg_pkg::VDBG_MODE_PASS: begin
        sel_data  = {24{1'b0}};
        sel_data[`VDBG_G_MSB:`VDBG_G_LSB] = s_axis_video_tdata[`VDBG_G_MSB:`VDBG_G_LSB];
        sel_last  = s_axis_video_tlast;
        sel_user  = s_axis_video_tuser;
        sel_valid = s_axis_video_tvalid;
      end
      vdbg_pkg::VDBG_MODE_NORMAL: begin
        sel_valid = conv_tvalid;
      end
      default: begin
        sel_valid = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // write channel: address and data are taken together, one word at a time
    st_next.awready = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid && !st_reg.awready;
    if (st_reg.awready) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = `VDBG_RESP_OKAY;
      case (waddr)
        `VDBG_OFS_CTRL: begin
          if (s_axi_wstrb[0] && DBG_ON) begin
            st_next.pass    = s_axi_wdata[`VDBG_BIT_PASS];
            st_next.pattern = s_axi_wdata[`VDBG_BIT_PATTERN];
          end
          if (s_axi_wstrb[3]) begin
            st_next.swrst = s_axi_wdata[`VDBG_BIT_SWRST];
          end
        end
        `VDBG_OFS_SIZE: begin
          if (s_axi_wstrb[1:0] == 2'b11) begin
            st_next.width = s_axi_wdata[12:0];
          end
          if (s_axi_wstrb[3:2] == 2'b11) begin
            st_next.height = s_axi_wdata[28:16];
          end
        end
        default: begin
          st_next.bresp = `VDBG_RESP_SLVERR;
        end
      endcase
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // read channel
    st_next.arready = s_axi_arvalid && !st_reg.rvalid && !st_reg.arready;
    if (st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `VDBG_RESP_OKAY;
      st_next.rdata  = {32{1'b0}};
      case (raddr)
        `VDBG_OFS_CTRL: begin
          st_next.rdata[`VDBG_BIT_PASS]    = st_reg.pass;
          st_next.rdata[`VDBG_BIT_PATTERN] = st_reg.pattern;
          st_next.rdata[`VDBG_BIT_SWRST]   = st_reg.swrst;
        end
        `VDBG_OFS_FRAME: st_next.rdata = st_reg.frames;
        `VDBG_OFS_LINE:  st_next.rdata = st_reg.lines;
        `VDBG_OFS_PIXEL: st_next.rdata = st_reg.pixels;
        `VDBG_OFS_SIZE:  st_next.rdata = {3'h0, st_reg.height, 3'h0, st_reg.width};
        default: begin
          st_next.rresp = `VDBG_RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // monitors count output transfers; 32-bit sums wrap by themselves
    if (pop && DBG_ON) begin
      st_next.pixels = st_reg.pixels + 32'h00000001;
      if (st_reg.out_last) begin
        st_next.lines = st_reg.lines + 32'h00000001;
      end
      if (st_reg.out_user) begin
        st_next.frames = st_reg.frames + 32'h00000001;
      end
    end
    // two-place stage: the skid slot lets the ready output come from a flop
    if (st_reg.skid_valid) begin
      if (pop) begin
        st_next.out_data   = st_reg.skid_data;
        st_next.out_last   = st_reg.skid_last;
        st_next.out_user   = st_reg.skid_user;
        st_next.skid_valid = 1'b0;
      end
    end else if (pop || !st_reg.out_valid) begin
      st_next.out_valid = acc;
      if (acc) begin
        st_next.out_data = sel_data;
        st_next.out_last = sel_last;
        st_next.out_user = sel_user;
      end
    end else if (acc) begin
      st_next.skid_data  = sel_data;
      st_next.skid_last  = sel_last;
      st_next.skid_user  = sel_user;
      st_next.skid_valid = 1'b1;
    end
    if (st_next.pattern) begin
      st_next.mode = vdbg_pkg::VDBG_MODE_PATTERN;
    end else if (st_next.pass) begin
      st_next.mode = vdbg_pkg::VDBG_MODE_PASS;
    end else begin
      st_next.mode = vdbg_pkg::VDBG_MODE_NORMAL;
    end
    st_next.in_ready   = !st_next.skid_valid;
    if (st_next.swrst) begin
      st_next.pass       = 1'b0;
      st_next.pattern    = 1'b0;
      st_next.width      = `VDBG_RST_WIDTH;
      st_next.height     = `VDBG_RST_HEIGHT;
      st_next.frames     = {32{1'b0}};
      st_next.lines      = {32{1'b0}};
      st_next.pixels     = {32{1'b0}};
      st_next.mode       = vdbg_pkg::VDBG_MODE_NORMAL;
      st_next.in_ready   = 1'b0;
      st_next.out_valid  = 1'b0;
      st_next.skid_valid = 1'b0;
    end
    st_next.s_ready    = st_next.in_ready && (st_next.mode == vdbg_pkg::VDBG_MODE_PASS);
    st_next.conv_ready = st_next.in_ready && (st_next.mode == vdbg_pkg::VDBG_MODE_NORMAL);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg        <= '0;
      st_reg.width  <= `VDBG_RST_WIDTH;
      st_reg.height <= `VDBG_RST_HEIGHT;
      st_reg.mode   <= vdbg_pkg::VDBG_MODE_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready       = st_reg.awready;
  assign s_axi_wready        = st_reg.awready;
  assign s_axi_bvalid        = st_reg.bvalid;
  assign s_axi_bresp         = st_reg.bresp;
  assign s_axi_arready       = st_reg.arready;
  assign s_axi_rvalid        = st_reg.rvalid;
  assign s_axi_rdata         = st_reg.rdata;
  assign s_axi_rresp         = st_reg.rresp;
  assign s_axis_video_tready = st_reg.s_ready;
  assign conv_tready         = st_reg.conv_ready;
  assign m_axis_video_tdata  = st_reg.out_data;
  assign m_axis_video_tvalid = st_reg.out_valid;
  assign m_axis_video_tlast  = st_reg.out_last;
  assign m_axis_video_tuser  = st_reg.out_user;
endmodule // vdbg_top
`default_nettype wire

// >>> verif/vdbg_stream_partner.sv
// stream partner: raw and converted sources plus a stalling sink
`timescale 1ns/100ps
`default_nettype none
module vdbg_stream_partner (
  input  wire logic        clk_sys,             // clock
  input  wire logic        nrst,                // reset, active low
  input  wire logic        src_en,              // sources offer samples
  input  wire logic        stall,               // sink refuses
  input  wire logic        s_axis_video_tready, // raw ready
  input  wire logic        conv_tready,         // converted ready
  output logic      [23:0] s_axis_video_tdata,  // raw sample
  output logic             s_axis_video_tvalid, // raw valid
  output logic             s_axis_video_tlast,  // raw end of line
  output logic             s_axis_video_tuser,  // raw start of frame
  output logic      [23:0] conv_tdata,          // converted sample
  output logic             conv_tvalid,         // converted valid
  output logic             conv_tlast,          // converted end of line
  output logic             conv_tuser,          // converted start of frame
  output logic             m_axis_video_tready  // sink ready
);
  logic [7:0] n0, n1;
  // lines of 8, frames of 4; an idle source shows inverted data, never a stale copy
  assign s_axis_video_tdata = {16'h5AA5, n0} ^ {24{!s_axis_video_tvalid}};
  assign conv_tdata = {16'h3CC3, n1} ^ {24{!conv_tvalid}};
  assign s_axis_video_tlast = n0[2:0] == 3'h7;
  assign s_axis_video_tuser = n0[4:0] == 5'h0;
  assign conv_tlast = n1[2:0] == 3'h7;
  assign conv_tuser = n1[4:0] == 5'h0;
  assign m_axis_video_tready = !stall;
  // valid is only withdrawn after its sample was taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {n0, n1, s_axis_video_tvalid, conv_tvalid} <= 18'h0;
    end else begin
      n0 <= n0 + 8'(s_axis_video_tvalid && s_axis_video_tready);
      n1 <= n1 + 8'(conv_tvalid && conv_tready);
      s_axis_video_tvalid <= src_en || (s_axis_video_tvalid && !s_axis_video_tready);
      conv_tvalid <= src_en || (conv_tvalid && !conv_tready);
    end
  end
endmodule // vdbg_stream_partner
`default_nettype wire

// >>> verif/vdbg_top_monitor.sv
// port checker for the video debug block
`timescale 1ns/100ps
`default_nettype none
`include "vdbg_consts.svh"
module vdbg_top_monitor (
  input wire logic        clk_sys,             // clock
  input wire logic        nrst,                // reset, active low
  input wire logic [7:0]  s_axi_awaddr,        // write address
  input wire logic        s_axi_awvalid,       // address valid
  input wire logic        s_axi_awready,       // address ready
  input wire logic [31:0] s_axi_wdata,         // write data
  input wire logic [3:0]  s_axi_wstrb,         // strobes
  input wire logic        s_axi_wvalid,        // data valid
  input wire logic [1:0]  s_axi_bresp,         // response
  input wire logic        s_axi_bvalid,        // response valid
  input wire logic        s_axi_bready,        // response ready
  input wire logic        s_axis_video_tready, // raw ready
  input wire logic        conv_tready,         // converted ready
  input wire logic [23:0] m_axis_video_tdata,  // output sample
  input wire logic        m_axis_video_tvalid, // output valid
  input wire logic        m_axis_video_tready  // output ready
);
  logic wr_ctrl, ro_hit, sw, sw1, sw2, pat, pat1, pat2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  assign wr_ctrl = s_axi_awready && s_axi_awaddr[7:2] == 6'h0;
  assign ro_hit = s_axi_awaddr[7:2] inside {6'h05, 6'h06, 6'h07};
  // shadow of the control bits; the delayed copies cover the mode switch latency
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {sw, sw1, sw2, pat, pat1, pat2} <= 6'h0;
    end else begin
      {sw1, sw2, pat1, pat2} <= {sw, sw1, pat, pat1};
      if (wr_ctrl && s_axi_wstrb[3]) sw <= s_axi_wdata[`VDBG_BIT_SWRST];
      if (wr_ctrl && s_axi_wstrb[0]) pat <= s_axi_wdata[`VDBG_BIT_PATTERN] && !sw;
      if (sw) pat <= 1'b0;
    end
  end
  a_wr_accept:
    assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
      |=> s_axi_awready) else $error("write not accepted");
  a_wr_resp:
    assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response missing");
  a_resp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  a_ro_slverr:
    assert property (s_axi_awready && ro_hit |=> s_axi_bresp == `VDBG_RESP_SLVERR)
      else $error("monitor write not refused");
  a_one_source:
    assert property (!(s_axis_video_tready && conv_tready)) else $error("two sources open");
  a_pat_owns:
    assert property (pat && pat2 |-> !s_axis_video_tready && !conv_tready)
      else $error("source open in pattern mode");
  a_swrst_quiet:
    assert property (sw && sw2 |-> !m_axis_video_tvalid && !s_axis_video_tready && !conv_tready)
      else $error("stream active in soft reset");
  a_out_hold:
    assert property (m_axis_video_tvalid && !m_axis_video_tready && !wr_ctrl && !sw
      |=> m_axis_video_tvalid && $stable(m_axis_video_tdata)) else $error("output not held");
endmodule // vdbg_top_monitor
bind vdbg_top vdbg_top_monitor u_mon (.*);
`default_nettype wire

// >>> verif/test_video_debug_features.sv
// self-checking bench for the video debug block
`timescale 1ns/100ps
`default_nettype none
`include "vdbg_consts.svh"
module test_video_debug_features;
  logic        clk_sys, nrst, src_en, stall;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [23:0] s_axis_video_tdata, conv_tdata, m_axis_video_tdata;
  logic        s_axis_video_tvalid, s_axis_video_tlast, s_axis_video_tuser, s_axis_video_tready;
  logic        conv_tvalid, conv_tlast, conv_tuser, conv_tready;
  logic        m_axis_video_tvalid, m_axis_video_tlast, m_axis_video_tuser, m_axis_video_tready;
  int          fail_count, checked, npix, nline, nframe, k;
  logic [25:0] mq [$];
  logic [7:0]  g;

  vdbg_top dut (.*);
  vdbg_stream_partner u_far (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (m_axis_video_tvalid === 1'b1 && m_axis_video_tready === 1'b1) begin
      mq.push_back({m_axis_video_tuser, m_axis_video_tlast, m_axis_video_tdata});
      npix++;
      nline += int'(m_axis_video_tlast);
      nframe += int'(m_axis_video_tuser);
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1 && ++t < 50);
    check("wready", 32'(s_axi_wready), 32'h1);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1 && ++t < 50);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1 && ++t < 50);
    {s_axi_arvalid, s_axi_rready} <= 2'h1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1 && ++t < 50);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, e);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  task automatic chk_cnt();
    rd(`VDBG_OFS_FRAME, 32'(nframe), 2'h0);
    rd(`VDBG_OFS_LINE, 32'(nline), 2'h0);
    rd(`VDBG_OFS_PIXEL, 32'(npix), 2'h0);
  endtask

  task automatic wait_q(input int n);
    for (int t = 0; t < 5000 && mq.size() < n; t++) @(posedge clk_sys);
  endtask

  // streams with a stalling sink, then compares every sample and the monitors
  task automatic run(input int n, input logic [15:0] hi);
    src_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      stall <= (i % 4 == 3);
      @(posedge clk_sys);
    end
    {src_en, stall} <= 2'h0;
    repeat (12) @(posedge clk_sys);
    check("moved", 32'(mq.size() > n / 2), 32'h1);
    foreach (mq[i]) begin
      check("upper", 32'(mq[i][23:8]), 32'(hi));
      if (i > 0) check("green", 32'(mq[i][7:0]), 32'(mq[i - 1][7:0] + 8'h1));
      // the far side marks line ends and frame starts from the same count it puts on green
      check("last", 32'(mq[i][24]), 32'(mq[i][2:0] == 3'h7));
      check("user", 32'(mq[i][25]), 32'(mq[i][4:0] == 5'h0));
    end
    mq.delete();
    chk_cnt();
  endtask

  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {nrst, src_en, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(`VDBG_OFS_SIZE, 32'h0438_0780, 2'h0);
    for (k = 0; k < 3; k++) rd(8'h14 + 8'(4 * k), 32'h0, 2'h0);
    rd(8'h24, 32'h0, `VDBG_RESP_SLVERR);
    wr(`VDBG_OFS_LINE, 32'h5, `VDBG_RESP_SLVERR);
    run(60, 16'h3CC3);
    wr(`VDBG_OFS_CTRL, 32'h10, 2'h0);
    run(60, 16'h0);
    wr(`VDBG_OFS_SIZE, 32'h0104_0208, 2'h0);
    wr(`VDBG_OFS_CTRL, 32'h30, 2'h0);
    wait_q(520);
    for (k = 0; k < 520; k++) begin
      check("bar", 32'(mq[k][23:0]), {8'h0, {8{k[6]}}, {8{k[8]}}, {8{k[7]}}});
    end
    check("eol_sof", 32'({mq[519][24], mq[518][24], mq[0][25]}), 32'h5);
    wr(`VDBG_OFS_CTRL, 32'h0, 2'h0);
    wr(`VDBG_OFS_SIZE, 32'h0104_0004, 2'h0);
    repeat (12) @(posedge clk_sys);
    mq.delete();
    wr(`VDBG_OFS_CTRL, 32'h20, 2'h0);
    wait_q(1032);
    for (k = 1024; k < 1032; k++) begin
      g = 8'(k % 4 + k / 4);
      check("ramp", 32'(mq[k][23:0]), {8'h0, g, g, g});
    end
    wr(`VDBG_OFS_CTRL, 32'h0, 2'h0);
    repeat (12) @(posedge clk_sys);
    chk_cnt();
    {stall, src_en} <= 2'h3;
    wr(`VDBG_OFS_CTRL, 32'h4000_0010, 2'h0);
    repeat (4) @(posedge clk_sys);
    check("idle", 32'({m_axis_video_tvalid, s_axis_video_tready, conv_tready}), 32'h0);
    npix = 0;
    nline = 0;
    nframe = 0;
    mq.delete();
    chk_cnt();
    rd(`VDBG_OFS_CTRL, 32'h4000_0000, 2'h0);
    rd(`VDBG_OFS_SIZE, 32'h0438_0780, 2'h0);
    wr(`VDBG_OFS_CTRL, 32'h0, 2'h0);
    run(40, 16'h3CC3);
    give_verdict();
  end

  // the whole sequence needs a few thousand cycles
  initial begin
    #(40000 * 4);
    fail_count++;
    give_verdict();
  end
endmodule // test_video_debug_features
`default_nettype wire
